// File: inc/sbdp_pkg.sv
// Purpose: shared constants and types for the system bus data phase block
// Assumes: one bus clock, logical active-high levels on every pin signal
// Notes: pin polarity inversion is done in the pad ring
package sbdp_pkg;

    localparam int unsigned SBDP_DATA_W = 64;
    localparam int unsigned SBDP_LANES = 8;
    localparam int unsigned SBDP_LANE_W = 8;
    localparam int unsigned SBDP_SLOTS = 4;
    localparam int unsigned SBDP_HANG_W = 16;
    localparam logic [15:0] SBDP_HANG_DEF = 16'h0100;

    localparam logic [2:0] SBDP_SINGLE_BEATS = 3'h1;
    localparam logic [2:0] SBDP_BURST_BEATS = 3'h4;
    localparam logic [2:0] SBDP_PORT32_BEATS = 3'h4;

    typedef enum logic [1:0] {
        SBDP_XFER_SINGLE = 2'h0,
        SBDP_XFER_BURST = 2'h1,
        SBDP_XFER_PORT32 = 2'h2
    } sbdp_xfer_t;

    typedef enum logic [2:0] {
        SBDP_IDLE = 3'h0,
        SBDP_REQ = 3'h1,
        SBDP_XFER = 3'h2,
        SBDP_REL = 3'h3
    } sbdp_state_t;

    typedef struct packed {
        logic valid;
        logic write;
        sbdp_xfer_t kind;
        logic [63:0] wdata;
    } sbdp_req_t;

    typedef struct packed {
        logic ready;
        logic done;
        logic error;
        logic parity_err;
        logic [63:0] rdata;
    } sbdp_rsp_t;

    // two-way pin, drive half
    typedef struct packed {
        logic out;
        logic oe_n;
    } sbdp_pin_t;

    function automatic logic [2:0] sbdp_beats(input sbdp_xfer_t kind);
        sbdp_beats = (kind == SBDP_XFER_SINGLE) ? SBDP_SINGLE_BEATS :
                     (kind == SBDP_XFER_BURST) ? SBDP_BURST_BEATS : SBDP_PORT32_BEATS;
    endfunction

    // odd parity per byte lane, lane 0 on bits 7:0
    function automatic logic [7:0] sbdp_odd_parity(input logic [63:0] d);
        sbdp_odd_parity = 8'h00;
        for (int i = 0; i < SBDP_LANES; i++) begin
            sbdp_odd_parity[i] = ~(^d[i*SBDP_LANE_W +: SBDP_LANE_W]);
        end
    endfunction

endpackage

// File: rtl/sbdp_parity.sv
// Purpose: byte-lane odd parity generate and check
// Assumes: data and parity sampled in the same cycle
// Notes: purely combinational
`timescale 1ns/1ps
module sbdp_parity (
    input wire logic [63:0] gen_data,
    input wire logic [63:0] chk_data,
    input wire logic [7:0] chk_parity,
    output logic [7:0] gen_parity,
    output logic [7:0] lane_err
);
    import sbdp_pkg::*;

    logic [7:0] chk_expect;

    assign gen_parity = sbdp_odd_parity(gen_data);
    assign chk_expect = sbdp_odd_parity(chk_data);

    genvar g;
    generate
        for (g = 0; g < SBDP_LANES; g++) begin : g_lane
            assign lane_err[g] = chk_expect[g] ^ chk_parity[g];
        end
    endgenerate

endmodule // sbdp_parity

// File: rtl/sbdp_arb.sv
// Purpose: bus arbiter for the internal master and three external slots
// Assumes: slot 0 internal, slots 1..3 external pin sets
// Notes: round robin, grant held while the request stays up
`timescale 1ns/1ps
module sbdp_arb (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic enable,
    input wire logic [3:0] req,
    input wire logic [2:0] same_family,
    input wire logic bus_busy,
    output logic [3:0] addr_grant,
    output logic [3:0] data_grant
);
    import sbdp_pkg::*;

    typedef struct packed {
        logic owner_v;
        logic [1:0] owner;
        logic [1:0] last;
    } sbdp_arb_st_t;

    sbdp_arb_st_t s_r;
    sbdp_arb_st_t s_nxt;

    function automatic logic [3:0] sbdp_onehot(input logic v, input logic [1:0] idx);
        sbdp_onehot = v ? (4'h1 << idx) : 4'h0;
    endfunction

    always_comb begin
        logic [1:0] idx;
        logic found;
        logic ok;
        idx = 2'h0;
        found = 1'b0;
        ok = 1'b0;
        s_nxt = s_r;
        if (!enable) begin
            s_nxt.owner_v = 1'b0;
        end else if (!(s_r.owner_v && req[s_r.owner])) begin
            s_nxt.owner_v = 1'b0;
            for (int i = 1; i <= SBDP_SLOTS; i++) begin
                idx = s_r.last + 2'(i);
                // another family only takes an idle bus
                ok = req[idx] && ((idx == 2'h0) || same_family[idx - 2'h1] || !bus_busy);
                if (ok && !found) begin
                    found = 1'b1;
                    s_nxt.owner_v = 1'b1;
                    s_nxt.owner = idx;
                    s_nxt.last = idx;
                end
            end
        end
    end

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    // single owner, so at most one data grant
    assign addr_grant = sbdp_onehot(s_r.owner_v, s_r.owner);
    assign data_grant = sbdp_onehot(s_r.owner_v && (!bus_busy || s_r.owner == 2'h0), s_r.owner);

endmodule // sbdp_arb

// File: rtl/sbdp_top.sv
// Purpose: data phase, parity, beat strobes, bus monitor and arbitration pins
// Assumes: the memory controller paces beats with mem_ready
// Notes: every pin output is registered; oe_n low while driving
//
// How it works
// - data driver also drives odd byte-lane parity
// - master drives writes, slave drives reads
// - single beat: one done strobe ends it
// - burst: four done strobes, fourth ends
// - done strobe always comes with valid strobe
// - 32-bit port double: three valid-only, then both
// - monitor flags hung transfer on error line
// - arbiter drives address and data grants
// - up to three external master pin sets
// - each set configured same or other family
// - first set requests bus when not arbiter
// - second and third sets only external masters
// - busy held for tenure, dropped, then released
`timescale 1ns/1ps
module sbdp_top #(
    parameter logic [15:0] HANG_CYCLES = sbdp_pkg::SBDP_HANG_DEF
) (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic arbiter_mode,
    input wire logic [2:0] same_family,
    input wire logic mem_ready,
    input wire sbdp_pkg::sbdp_req_t int_req,
    output sbdp_pkg::sbdp_rsp_t int_rsp,
    input wire logic [63:0] data_in,
    output logic [63:0] data_out,
    output logic data_oe_n,
    input wire logic [7:0] lane_parity_in,
    output logic [7:0] lane_parity_out,
    output logic lane_parity_oe_n,
    input wire logic beat_done_strobe_in,
    output sbdp_pkg::sbdp_pin_t beat_done_strobe,
    input wire logic beat_valid_strobe_in,
    output sbdp_pkg::sbdp_pin_t beat_valid_strobe,
    input wire logic bus_error_flag_in,
    output sbdp_pkg::sbdp_pin_t bus_error_flag,
    input wire logic data_tenure_busy_in,
    output sbdp_pkg::sbdp_pin_t data_tenure_busy,
    input wire logic ownership_request_in,
    output sbdp_pkg::sbdp_pin_t ownership_request,
    input wire logic ownership_grant_in,
    output sbdp_pkg::sbdp_pin_t ownership_grant,
    input wire logic data_phase_grant_in,
    output sbdp_pkg::sbdp_pin_t data_phase_grant,
    input wire logic second_master_request,
    output logic second_master_grant,
    output logic second_master_phase_grant,
    input wire logic third_master_request,
    output logic third_master_grant,
    output logic third_master_phase_grant
);
    import sbdp_pkg::*;

    typedef struct packed {
        sbdp_state_t st;
        logic write;
        sbdp_xfer_t kind;
        logic [63:0] wdata;
        logic [2:0] beat_cnt;
        logic [15:0] hang;
        logic [15:0] mon;
        sbdp_rsp_t rsp;
        logic [63:0] dout;
        logic dout_oe_n;
        logic [7:0] pout;
        sbdp_pin_t bdone;
        sbdp_pin_t bval;
        sbdp_pin_t berr;
        sbdp_pin_t busy;
        sbdp_pin_t oreq;
        sbdp_pin_t ogrant;
        sbdp_pin_t dgrant;
        logic [1:0] ext_grant;
        logic [1:0] ext_dgrant;
    } sbdp_top_st_t;

    sbdp_top_st_t s_r;
    sbdp_top_st_t s_nxt;

    logic [7:0] gen_parity;
    logic [7:0] lane_err;
    logic [3:0] arb_req;
    logic [3:0] arb_agrant;
    logic [3:0] arb_dgrant;
    logic own_tenure;
    logic got_bus;
    logic last_beat;

    // ************************************************************
    // parity and arbiter
    // ************************************************************
    sbdp_parity sbdp_parity_i (
        .gen_data(s_r.wdata),
        .chk_data(data_in),
        .chk_parity(lane_parity_in),
        .gen_parity(gen_parity),
        .lane_err(lane_err)
    );

    assign own_tenure = (s_r.st != SBDP_IDLE);
    // slot 0 holds its request through the whole tenure
    assign arb_req = {third_master_request, second_master_request, ownership_request_in,
                      arbiter_mode && own_tenure};

    sbdp_arb sbdp_arb_i (
        .core_clk(core_clk),
        .reset(reset),
        .enable(arbiter_mode),
        .req(arb_req),
        .same_family(same_family),
        .bus_busy(data_tenure_busy_in),
        .addr_grant(arb_agrant),
        .data_grant(arb_dgrant)
    );

    assign got_bus = arbiter_mode ? arb_dgrant[0] : (ownership_grant_in && data_phase_grant_in);
    assign last_beat = (s_r.beat_cnt + 3'h1) == sbdp_beats(s_r.kind);

    // ************************************************************
    // next state
    // ************************************************************
    always_comb begin
        s_nxt = s_r;
        s_nxt.rsp.done = 1'b0;
        s_nxt.rsp.error = 1'b0;
        s_nxt.bdone.out = 1'b0;
        s_nxt.bval.out = 1'b0;
        s_nxt.berr = '{out: 1'b0, oe_n: 1'b1};

        // grant pins, direction set by arbiter role
        s_nxt.ogrant = '{out: arb_agrant[1], oe_n: !arbiter_mode};
        s_nxt.dgrant = '{out: arb_dgrant[1], oe_n: !arbiter_mode};
        s_nxt.ext_grant = arbiter_mode ? arb_agrant[3:2] : 2'h0;
        s_nxt.ext_dgrant = arbiter_mode ? arb_dgrant[3:2] : 2'h0;
        s_nxt.oreq = '{out: 1'b0, oe_n: arbiter_mode};

        unique case (s_r.st)
            SBDP_IDLE: begin
                s_nxt.bdone.oe_n = 1'b1;
                s_nxt.bval.oe_n = 1'b1;
                s_nxt.busy.oe_n = 1'b1;
                s_nxt.dout_oe_n = 1'b1;
                if (int_req.valid) begin
                    s_nxt.write = int_req.write;
                    s_nxt.kind = int_req.kind;
                    s_nxt.wdata = int_req.wdata;
                    s_nxt.rsp.parity_err = 1'b0;
                    s_nxt.st = SBDP_REQ;
                end
            end
            SBDP_REQ: begin
                s_nxt.oreq.out = !arbiter_mode;
                if (got_bus && !data_tenure_busy_in) begin
                    s_nxt.oreq.out = 1'b0;
                    s_nxt.st = SBDP_XFER;
                    s_nxt.beat_cnt = 3'h0;
                    s_nxt.hang = '0;
                    s_nxt.busy = '{out: 1'b1, oe_n: 1'b0};
                    s_nxt.bdone.oe_n = 1'b0;
                    s_nxt.bval.oe_n = 1'b0;
                    s_nxt.dout = s_r.wdata;
                    s_nxt.pout = gen_parity;
                    s_nxt.dout_oe_n = !s_r.write;
                end
            end
            SBDP_XFER: begin
                if (bus_error_flag_in || s_r.hang == HANG_CYCLES - 16'h0001) begin
                    s_nxt.berr = '{out: !bus_error_flag_in, oe_n: bus_error_flag_in};
                    s_nxt.rsp.error = 1'b1;
                    s_nxt.rsp.done = 1'b1;
                    s_nxt.st = SBDP_REL;
                end else if (mem_ready) begin
                    s_nxt.hang = '0;
                    s_nxt.bval.out = 1'b1;
                    s_nxt.bdone.out = last_beat || (s_r.kind != SBDP_XFER_PORT32);
                    s_nxt.beat_cnt = s_r.beat_cnt + 3'h1;
                    if (!s_r.write) begin
                        s_nxt.rsp.rdata = data_in;
                        s_nxt.rsp.parity_err = s_r.rsp.parity_err | (|lane_err);
                    end
                    if (last_beat) begin
                        s_nxt.rsp.done = 1'b1;
                        s_nxt.st = SBDP_REL;
                    end
                end else begin
                    s_nxt.hang = s_r.hang + 16'h0001;
                end
            end
            SBDP_REL: begin
                // busy driven low for a cycle before release
                s_nxt.busy.out = 1'b0;
                s_nxt.dout_oe_n = 1'b1;
                s_nxt.st = SBDP_IDLE;
            end
            default: begin
                s_nxt.st = SBDP_IDLE;
            end
        endcase

        // watchdog over tenures of other masters
        if (s_r.st != SBDP_XFER && data_tenure_busy_in && !beat_valid_strobe_in) begin
            s_nxt.mon = s_r.mon + 16'h0001;
            if (s_r.mon == HANG_CYCLES - 16'h0001) begin
                s_nxt.berr = '{out: 1'b1, oe_n: 1'b0};
                s_nxt.mon = '0;
            end
        end else begin
            s_nxt.mon = '0;
        end
        s_nxt.rsp.ready = (s_nxt.st == SBDP_IDLE);
    end

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            s_r <= '0;
            s_r.rsp.ready <= 1'b1;
            s_r.dout_oe_n <= 1'b1;
            s_r.bdone.oe_n <= 1'b1;
            s_r.bval.oe_n <= 1'b1;
            s_r.berr.oe_n <= 1'b1;
            s_r.busy.oe_n <= 1'b1;
            s_r.oreq.oe_n <= 1'b1;
            s_r.ogrant.oe_n <= 1'b1;
            s_r.dgrant.oe_n <= 1'b1;
        end else begin
            s_r <= s_nxt;
        end
    end

    // ************************************************************
    // outputs
    // ************************************************************
    assign int_rsp = s_r.rsp;
    assign data_out = s_r.dout;
    assign data_oe_n = s_r.dout_oe_n;
    assign lane_parity_out = s_r.pout;
    assign lane_parity_oe_n = s_r.dout_oe_n;
    assign beat_done_strobe = s_r.bdone;
    assign beat_valid_strobe = s_r.bval;
    assign bus_error_flag = s_r.berr;
    assign data_tenure_busy = s_r.busy;
    assign ownership_request = s_r.oreq;
    assign ownership_grant = s_r.ogrant;
    assign data_phase_grant = s_r.dgrant;
    assign second_master_grant = s_r.ext_grant[0];
    assign second_master_phase_grant = s_r.ext_dgrant[0];
    assign third_master_grant = s_r.ext_grant[1];
    assign third_master_phase_grant = s_r.ext_dgrant[1];

    // ************************************************************
    // checks
    // ************************************************************
    chk_parity_odd: assert property (@(posedge core_clk) disable iff (reset)
        !lane_parity_oe_n |-> lane_parity_out == sbdp_odd_parity(data_out))
        else $error("lane parity not odd");
    chk_done_valid: assert property (@(posedge core_clk) disable iff (reset)
        beat_done_strobe.out |-> beat_valid_strobe.out)
        else $error("done strobe without valid strobe");
    chk_single_end: assert property (@(posedge core_clk) disable iff (reset)
        beat_done_strobe.out && s_r.kind == SBDP_XFER_SINGLE |-> s_r.beat_cnt == 3'h1 ##1 !data_tenure_busy.out)
        else $error("single transfer not ended by one done strobe");
    chk_burst_four: assert property (@(posedge core_clk) disable iff (reset)
        beat_done_strobe.out && s_r.kind == SBDP_XFER_BURST && s_r.beat_cnt != 3'h4 |=> data_tenure_busy.out)
        else $error("burst ended before fourth done strobe");
    chk_port32_three: assert property (@(posedge core_clk) disable iff (reset)
        beat_valid_strobe.out && s_r.kind == SBDP_XFER_PORT32 |-> beat_done_strobe.out == (s_r.beat_cnt == 3'h4))
        else $error("narrow port strobe pattern wrong");
    chk_busy_release: assert property (@(posedge core_clk) disable iff (reset)
        $fell(data_tenure_busy.out) && !data_tenure_busy.oe_n |=> data_tenure_busy.oe_n)
        else $error("busy not released after drop");
    chk_hang_error: assert property (@(posedge core_clk) disable iff (reset)
        s_r.st == SBDP_XFER && s_r.hang == HANG_CYCLES - 16'h0001 && !bus_error_flag_in
        |=> bus_error_flag.out && !bus_error_flag.oe_n ##1 bus_error_flag.oe_n)
        else $error("hung transfer not flagged");
    chk_one_data_grant: assert property (@(posedge core_clk) disable iff (reset)
        $onehot0({data_phase_grant.out && !data_phase_grant.oe_n, second_master_phase_grant, third_master_phase_grant}))
        else $error("two data grants at once");
    chk_grant_pair: assert property (@(posedge core_clk) disable iff (reset)
        second_master_phase_grant || third_master_phase_grant |->
        (second_master_grant == second_master_phase_grant) && (third_master_grant == third_master_phase_grant))
        else $error("data grant without address grant");
    chk_ext_arb_only: assert property (@(posedge core_clk) disable iff (reset)
        !arbiter_mode ##1 !arbiter_mode |-> !second_master_grant && !third_master_grant)
        else $error("external grant outside arbiter role");

    cov_burst: cover property (@(posedge core_clk) disable iff (reset)
        beat_done_strobe.out && s_r.kind == SBDP_XFER_BURST && s_r.beat_cnt == 3'h4);
    cov_port32: cover property (@(posedge core_clk) disable iff (reset)
        beat_done_strobe.out && s_r.kind == SBDP_XFER_PORT32);
    cov_hang: cover property (@(posedge core_clk) disable iff (reset)
        bus_error_flag.out);

endmodule // sbdp_top

// File: testbench/sbdp_partner.sv
// Purpose: far-side model: memory slave pacing beats, read data source, outside arbiter
// Assumes: logical active-high levels; the bench resolves every two-way wire
// Notes: drives on the falling edge; released data shows the inverse of the word
`timescale 1ns/1ps
module sbdp_partner (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic arbiter_mode,
    input wire logic hang,
    input wire logic [1:0] stall,
    input wire logic bad_par,
    input wire logic [63:0] rd_word,
    input wire sbdp_pkg::sbdp_pin_t busy_pin,
    input wire sbdp_pkg::sbdp_pin_t req_pin,
    output logic mem_ready,
    output logic [63:0] slave_data,
    output logic [7:0] slave_parity,
    output logic grant
);
    import sbdp_pkg::*;
    logic [1:0] wait_r;

    // ************************************
    // beat pacing and outside arbiter
    // ************************************
    always @(negedge core_clk or posedge reset) begin
        if (reset) begin
            wait_r <= 2'h0;
            mem_ready <= 1'b0;
            grant <= 1'b0;
        end else begin
            // grant held until the tenure is over
            grant <= !arbiter_mode && ((!req_pin.oe_n && req_pin.out) || (grant && !busy_pin.oe_n));
            if (!busy_pin.oe_n && busy_pin.out && !hang) begin
                mem_ready <= (wait_r == stall);
                wait_r <= (wait_r == stall) ? 2'h0 : wait_r + 2'h1;
            end else begin
                mem_ready <= 1'b0;
                wait_r <= 2'h0;
            end
        end
    end

    // ************************************
    // read data and lane parity
    // ************************************
    always_comb begin
        slave_data = mem_ready ? rd_word : ~rd_word;
        for (int i = 0; i < 8; i++) begin
            slave_parity[i] = ~(^slave_data[8*i +: 8]);
        end
        slave_parity[0] = slave_parity[0] ^ (bad_par & mem_ready);
    end
endmodule // sbdp_partner

// File: testbench/sbdp_tb_top.sv
// Purpose: self-checking bench for the data phase and arbitration block
// Assumes: bench drives on the falling edge; hang limit shortened to 8
// Notes: two-way wires resolved here from the block's enables
`timescale 1ns/1ps
module system_bus_data_phase_arbitration_tb_top;
    import sbdp_pkg::*;
    logic core_clk, reset, arbiter_mode, mem_ready, hang, bad_par, ext_busy, ext_req1, grant;
    logic sec_req, thr_req, ext_err, second_master_grant, second_master_phase_grant;
    logic saw_req = 1'b0;
    logic third_master_grant, third_master_phase_grant, data_oe_n, lane_parity_oe_n;
    logic [1:0] stall;
    logic [2:0] same_family;
    logic [63:0] rd_word, data_out, slave_data;
    logic [7:0] lane_parity_out, slave_parity;
    sbdp_req_t int_req;
    sbdp_rsp_t int_rsp;
    sbdp_pin_t done_p, valid_p, err_p, busy_p, oreq_p, ogrant_p, ophase_p;
    int bad_count = 0;
    int check_count = 0;

    sbdp_top #(.HANG_CYCLES(16'h0008)) sbdp_top_i (.core_clk(core_clk), .reset(reset),
        .arbiter_mode(arbiter_mode), .same_family(same_family), .mem_ready(mem_ready),
        .int_req(int_req), .int_rsp(int_rsp), .data_in(data_oe_n ? slave_data : data_out),
        .data_out(data_out), .data_oe_n(data_oe_n),
        .lane_parity_in(lane_parity_oe_n ? slave_parity : lane_parity_out),
        .lane_parity_out(lane_parity_out), .lane_parity_oe_n(lane_parity_oe_n),
        .beat_done_strobe_in(!done_p.oe_n && done_p.out), .beat_done_strobe(done_p),
        .beat_valid_strobe_in(!valid_p.oe_n && valid_p.out), .beat_valid_strobe(valid_p),
        .bus_error_flag_in((!err_p.oe_n && err_p.out) || ext_err), .bus_error_flag(err_p),
        .data_tenure_busy_in(busy_p.oe_n ? ext_busy : busy_p.out), .data_tenure_busy(busy_p),
        .ownership_request_in(oreq_p.oe_n ? ext_req1 : oreq_p.out), .ownership_request(oreq_p),
        .ownership_grant_in(ogrant_p.oe_n ? grant : ogrant_p.out), .ownership_grant(ogrant_p),
        .data_phase_grant_in(ophase_p.oe_n ? grant : ophase_p.out), .data_phase_grant(ophase_p),
        .second_master_request(sec_req), .second_master_grant(second_master_grant),
        .second_master_phase_grant(second_master_phase_grant), .third_master_request(thr_req),
        .third_master_grant(third_master_grant), .third_master_phase_grant(third_master_phase_grant));

    sbdp_partner sbdp_partner_i (.core_clk(core_clk), .reset(reset), .arbiter_mode(arbiter_mode),
        .hang(hang), .stall(stall), .bad_par(bad_par), .rd_word(rd_word), .busy_pin(busy_p),
        .req_pin(oreq_p), .mem_ready(mem_ready), .slave_data(slave_data),
        .slave_parity(slave_parity), .grant(grant));

    // ************************************
    // common tasks
    // ************************************
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    always @(negedge core_clk) if (!oreq_p.oe_n && oreq_p.out) saw_req = 1'b1;

    task automatic finish_test();
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        check_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    function automatic logic [7:0] odd_par(input logic [63:0] d);
        logic [7:0] p;
        for (int i = 0; i < 8; i++) p[i] = ~(^d[8*i +: 8]);
        return p;
    endfunction

    task automatic wait_on(input logic cond_seen);
        if (!cond_seen) begin
            bad_count++;
            finish_test();
        end
    endtask

    task automatic do_reset(input logic mode);
        @(negedge core_clk);
        reset = 1'b1;
        arbiter_mode = mode;
        repeat (2) @(negedge core_clk);
        reset = 1'b0;
    endtask

    // one transfer; counts strobes and judges the tenure
    task automatic xfer(input logic wr, input sbdp_xfer_t kind, input logic [63:0] wd,
                        input logic [2:0] n_valid, input logic [2:0] n_done, input logic exp_err);
        logic [2:0] nv, nd;
        logic ne;
        int k;
        nv = 3'h0;
        nd = 3'h0;
        ne = 1'b0;
        for (k = 0; k < 10 && int_rsp.ready !== 1'b1; k++) @(negedge core_clk);
        wait_on(k < 10);
        int_req = '{valid: 1'b1, write: wr, kind: kind, wdata: wd};
        @(negedge core_clk);
        int_req.valid = 1'b0;
        for (k = 0; k < 200 && int_rsp.done !== 1'b1; k++) begin
            @(negedge core_clk);
            ne = ne | (!err_p.oe_n && err_p.out) | ext_err;
            if (!done_p.oe_n && done_p.out) begin
                nd++;
                check({63'h0, valid_p.out}, 64'h1);
            end
            if (!valid_p.oe_n && valid_p.out) begin
                nv++;
                check({62'h0, busy_p.out, busy_p.oe_n}, 64'h2);
                check({63'h0, data_oe_n}, {63'h0, !wr});
                if (wr && kind != SBDP_XFER_PORT32) begin
                    check(data_out, wd);
                    check({55'h0, lane_parity_oe_n, lane_parity_out}, {56'h0, odd_par(wd)});
                end
            end
        end
        wait_on(k < 200);
        check({61'h0, nv}, {61'h0, n_valid});
        check({61'h0, nd}, {61'h0, n_done});
        check({63'h0, int_rsp.error}, {63'h0, exp_err});
        if (!wr && !exp_err) check(int_rsp.rdata, rd_word);
        @(negedge core_clk);
        ne = ne | (!err_p.oe_n && err_p.out) | ext_err;
        check({62'h0, busy_p.out, busy_p.oe_n}, 64'h0);
        @(negedge core_clk);
        check({63'h0, busy_p.oe_n}, 64'h1);
        check({63'h0, ne}, {63'h0, exp_err});
    endtask

    // ************************************
    // scenarios
    // ************************************
    task automatic run_beats();
        xfer(1'b1, SBDP_XFER_SINGLE, 64'h0123_4567_89ab_cdef, 3'h1, 3'h1, 1'b0);
        rd_word = 64'hfe01_7f80_00ff_5aa5;
        xfer(1'b0, SBDP_XFER_SINGLE, 64'h0, 3'h1, 3'h1, 1'b0);
        check({63'h0, int_rsp.parity_err}, 64'h0);
        stall = 2'h2;
        xfer(1'b1, SBDP_XFER_BURST, 64'h8000_0000_0000_0001, 3'h4, 3'h4, 1'b0);
        stall = 2'h0;
        xfer(1'b0, SBDP_XFER_BURST, 64'h0, 3'h4, 3'h4, 1'b0);
        xfer(1'b1, SBDP_XFER_PORT32, 64'h5555_aaaa_3c3c_c3c3, 3'h4, 3'h1, 1'b0);
        xfer(1'b0, SBDP_XFER_PORT32, 64'h0, 3'h4, 3'h1, 1'b0);
    endtask

    task automatic run_faults();
        bad_par = 1'b1;
        xfer(1'b0, SBDP_XFER_SINGLE, 64'h0, 3'h1, 3'h1, 1'b0);
        check({63'h0, int_rsp.parity_err}, 64'h1);
        bad_par = 1'b0;
        hang = 1'b1;
        xfer(1'b1, SBDP_XFER_SINGLE, 64'h1111_2222_3333_4444, 3'h0, 3'h0, 1'b1);
        hang = 1'b0;
        // outside error line aborts a burst before any beat
        ext_err = 1'b1;
        xfer(1'b0, SBDP_XFER_BURST, 64'h0, 3'h0, 3'h0, 1'b1);
        ext_err = 1'b0;
    endtask

    task automatic run_arb();
        logic [2:0] got;
        int k;
        got = 3'h0;
        same_family = 3'b101;
        ext_req1 = 1'b1;
        sec_req = 1'b1;
        thr_req = 1'b1;
        for (k = 0; k < 80 && got != 3'h7; k++) begin
            @(negedge core_clk);
            check({63'h0, (second_master_phase_grant + third_master_phase_grant
                + (ophase_p.out & !ophase_p.oe_n)) > 2'h1}, 64'h0);
            if (ogrant_p.out && !ogrant_p.oe_n && ophase_p.out && !ophase_p.oe_n) begin
                got[0] = 1'b1;
                ext_req1 = 1'b0;
            end
            if (second_master_grant && second_master_phase_grant) begin
                got[1] = 1'b1;
                sec_req = 1'b0;
            end
            if (third_master_grant && third_master_phase_grant) begin
                got[2] = 1'b1;
                thr_req = 1'b0;
            end
        end
        check({61'h0, got}, 64'h7);
        repeat (4) @(negedge core_clk);
        check({62'h0, second_master_grant, third_master_grant}, 64'h0);
        same_family = 3'b000;
        ext_busy = 1'b1;
        sec_req = 1'b1;
        repeat (8) @(negedge core_clk);
        check({63'h0, second_master_grant}, 64'h0);
        check({62'h0, err_p.out, err_p.oe_n}, 64'h2);
        ext_busy = 1'b0;
        for (k = 0; k < 10 && second_master_grant !== 1'b1; k++) @(negedge core_clk);
        check({63'h0, second_master_grant}, 64'h1);
        sec_req = 1'b0;
        repeat (4) @(negedge core_clk);
    endtask

    task automatic run_outside_arbiter();
        do_reset(1'b0);
        xfer(1'b1, SBDP_XFER_SINGLE, 64'h00ff_00ff_f0f0_0f0f, 3'h1, 3'h1, 1'b0);
        check({63'h0, saw_req}, 64'h1);
    endtask

    initial begin
        reset = 1'b1;
        arbiter_mode = 1'b1;
        same_family = 3'b111;
        int_req = '0;
        hang = 1'b0;
        bad_par = 1'b0;
        stall = 2'h0;
        rd_word = 64'h0;
        ext_busy = 1'b0;
        ext_req1 = 1'b0;
        sec_req = 1'b0;
        thr_req = 1'b0;
        ext_err = 1'b0;
        do_reset(1'b1);
        run_beats();
        run_faults();
        run_arb();
        run_outside_arbiter();
        finish_test();
    end
endmodule // system_bus_data_phase_arbitration_tb_top
